//--- core/cpu_bus_reset_control.sv
// bus control, bus handover, interlock, reset and status word of the processor
// How it works
// - byte writes fill all lanes; halfwords are copied to unused lanes except at offset 1.
// - when granted, bus outputs float, grant ack low, reset and relinquish ack high.
// - strap low makes us arbiter; strap high makes us request the bus.
// - swap exchanges operands; conditional swap only when the operands are equal.
// - between locked read and its write no handover or request except reset.
// - reset, however raised, wins over and aborts any activity.
// - reset request low brings reset acknowledge and a safe output state.
// - acknowledge stays 128 cycles after request release, then boot starts.
// - after acknowledge, arbiter drives strobes high and size low; else floats.
// - the open-drain relinquish acknowledge is never driven during reset; it is driven only while relinquished.
// - address-mode indicator is physical no later than 66 cycles after acknowledge.
// - access mode is kernel no later than 18 cycles after acknowledge.
// - boot reads pointer at 0x80, then status, counter at +4, stack at +8.
// - relinquish request ends access, frees bus, repeats access when returned.
// - retry input ends the access and performs it again.
// - fault input ends the access and enters exception handling.
// - relinquish beats retry beats fault; fault counts on the retried access.
// - exception type bits 1:0: reset, process, stack, normal.
// - trace mask is set at instruction start and cleared on a fault.
// - internal state code names the exception; highest priority wins.
// - status bit 7 selects starting a process from initial context.
// - status bit 8 selects register saving; external reset clears it.
// - the status word has the fixed field layout of general register 11.
`include "cpu_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_reset_control #(
	parameter int HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
	input wire logic clk_i, // 100 MHz clock
	input wire logic reset_i, // synchronous reset, high
	input wire logic ce_i, // clock enable, freezes all state
	input wire logic [5:0] avs_address_i, // register byte address
	input wire logic avs_read_i, // register read
	input wire logic avs_write_i, // register write
	input wire logic [31:0] avs_writedata_i, // register write data
	input wire logic [3:0] avs_byteenable_i, // write byte lanes
	output logic [31:0] avs_readdata_o, // register read data
	output logic avs_waitrequest_o, // stall
	input wire logic reset_request_n_i, // system reset request pin
	input wire logic arbiter_select_strap_i, // low: we are arbiter
	input wire logic bus_hold_request_n_i, // outside master wants bus
	input wire logic bus_grant_n_i, // outside arbiter grants bus
	input wire logic relinquish_retry_request_n_i, // relinquish and retry
	input wire logic retry_n_i, // retry current access
	input wire logic fault_n_i, // fault on current access
	input wire logic data_ready_strobe_n_i, // access completes
	input wire logic [31:0] data_i, // read data pins
	output logic [31:0] data_o, // write data pins
	output logic data_oe_o, // data pins driven
	output logic [31:0] addr_o, // address pins
	output logic addr_oe_o, // address pins driven
	output logic [2:0] transfer_size_outputs_o, // size pins
	output logic size_oe_o, // size pins driven
	output logic addr_strobe_n_o, // address strobe
	output logic data_strobe_n_o, // data strobe
	output logic read_not_write_o, // 1 read, 0 write
	output logic strobe_oe_o, // strobes driven
	output logic virtual_address_indicator_o, // 1 physical mode
	output logic [1:0] access_mode_outputs_o, // execution level
	output logic mode_oe_o, // mode pins driven
	output logic bus_grant_ack_n_o, // bus given away
	output logic bus_hold_request_n_o, // we want the bus
	output logic reset_ack_n_o, // reset acknowledge
	output logic relinquish_retry_ack_o, // open drain level, always 0
	output logic relinquish_retry_ack_oe_o, // pulls the ack low
	output logic [1:0] queue_status_outputs_o, // queue status
	output logic instruction_start_n_o, // start of instruction
	output logic initial_context_o, // status bit 7
	output logic save_registers_o // status bit 8
);
	typedef struct packed {
		cpu_bus_pkg::state_t state;
		logic [7:0] s1;
		logic [7:0] s2;
		logic arb;
		logic [7:0] cnt;
		logic [6:0] since;
		logic boot;
		logic [1:0] step;
		logic pend;
		logic busy;
		logic lock;
		logic write;
		logic fault;
		logic equal;
		logic start;
		logic rd_ack;
		cpu_bus_pkg::op_t op;
		cpu_bus_pkg::size_t size;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] cmp;
		logic [31:0] rdata;
		logic [31:0] process_control_block;
		logic [31:0] pc;
		logic [31:0] sp;
		logic [31:0] dout;
		logic [31:0] rdbus;
		logic [31:0] d1;
		logic [31:0] d2;
		cpu_bus_pkg::psw_t processor_status_word;
	} ctl_t;

	localparam int IX_RST = 0;
	localparam int IX_HOLD = 1;
	localparam int IX_RELINQUISH_RETRY_REQUEST = 2;
	localparam int IX_RETRY = 3;
	localparam int IX_FAULT = 4;
	localparam int IX_DATA_READY_STROBE = 5;
	localparam int IX_GRANT = 6;
	localparam int IX_STRAP = 7;
	localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);

	ctl_t r;
	ctl_t n;
	logic [31:0] lanes;
	logic [31:0] be_mask;
	logic owns_bus;
	logic floated;
	logic in_reset;

	write_lane_replicator u_lanes (
		.offset_i(r.addr[1:0]),
		.size_i(r.size),
		.data_i(r.wdata),
		.lanes_o(lanes)
	);

	assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign in_reset = (r.state == cpu_bus_pkg::ST_RESET_HOLD) || (r.state == cpu_bus_pkg::ST_RESET_COUNT);
	assign owns_bus = (r.state == cpu_bus_pkg::ST_ACCESS) || (r.state == cpu_bus_pkg::ST_LOCKED) ||
		(r.state == cpu_bus_pkg::ST_RETRY);
	assign floated = (r.state == cpu_bus_pkg::ST_GRANTED) || (r.state == cpu_bus_pkg::ST_RELINQ);

	// register read mux
	function automatic logic [31:0] reg_read(input ctl_t c, input logic [5:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == `REG_PSW) v = c.processor_status_word;
		else if (a == `REG_ADDR) v = c.addr;
		else if (a == `REG_WDATA) v = c.wdata;
		else if (a == `REG_CMP) v = c.cmp;
		else if (a == `REG_CTRL) v = {19'h0, c.state == cpu_bus_pkg::ST_GRANTED, c.equal, c.fault,
			c.busy | c.pend, 3'h0, c.op, c.write, c.size};
		else if (a == `REG_RDATA) v = c.rdata;
		else if (a == `REG_PCB) v = c.process_control_block;
		else if (a == `REG_PC) v = c.pc;
		else if (a == `REG_SP) v = c.sp;
		return v;
	endfunction : reg_read

	// next state of the whole block
	always_comb begin
		n = r;
		n.s1 = {arbiter_select_strap_i, bus_grant_n_i, data_ready_strobe_n_i, fault_n_i, retry_n_i,
			relinquish_retry_request_n_i, bus_hold_request_n_i, reset_request_n_i};
		n.s2 = r.s1;
		// read data pins pass two flops, in step with the synced data ready
		n.d1 = data_i;
		n.d2 = r.d1;
		n.start = 1'b0;
		n.dout = lanes;
		n.rd_ack = avs_read_i && !r.rd_ack;
		if (avs_read_i && !r.rd_ack) n.rdbus = reg_read(r, avs_address_i);
		if (!in_reset && r.since != 7'h7F) n.since = r.since + 7'h01;
		// register writes; access setup only while idle
		if (avs_write_i && !in_reset) begin
			if (avs_address_i == `REG_PSW) begin
				n.processor_status_word = (r.processor_status_word & ~(`PSW_WR_MASK & be_mask)) | (avs_writedata_i & `PSW_WR_MASK & be_mask);
			end else if (avs_address_i == `REG_ADDR && !r.busy && !r.pend) begin
				n.addr = (r.addr & ~be_mask) | (avs_writedata_i & be_mask);
			end else if (avs_address_i == `REG_WDATA && !r.busy && !r.pend) begin
				n.wdata = (r.wdata & ~be_mask) | (avs_writedata_i & be_mask);
			end else if (avs_address_i == `REG_CMP && !r.busy && !r.pend) begin
				n.cmp = (r.cmp & ~be_mask) | (avs_writedata_i & be_mask);
			end else if (avs_address_i == `REG_CTRL && !r.busy && !r.pend) begin
				n.size = cpu_bus_pkg::size_t'(avs_writedata_i[1:0]);
				n.op = cpu_bus_pkg::op_t'(avs_writedata_i[4:3]);
				n.lock = avs_writedata_i[4:3] != 2'h0;
				n.write = avs_writedata_i[2] && avs_writedata_i[4:3] == 2'h0;
				n.pend = 1'b1;
				n.fault = 1'b0;
				n.processor_status_word.trace_mask_bit = 1'b1;
				n.start = 1'b1;
			end
		end
		case (r.state)
			cpu_bus_pkg::ST_RESET_HOLD: begin
				n.arb = !r.s2[IX_STRAP];
				if (r.s2[IX_RST]) begin
					n.state = cpu_bus_pkg::ST_RESET_COUNT;
					n.cnt = 8'h00;
				end
			end
			cpu_bus_pkg::ST_RESET_COUNT: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt == HOLD_LAST) begin
					n.boot = 1'b1;
					n.step = 2'h0;
					n.busy = 1'b1;
					n.write = 1'b0;
					n.size = cpu_bus_pkg::SZ_WORD;
					n.addr = `BOOT_VECTOR_ADDR;
					n.state = r.arb ? cpu_bus_pkg::ST_ACCESS : cpu_bus_pkg::ST_REQ_BUS;
				end
			end
			cpu_bus_pkg::ST_IDLE: begin
				if (r.arb && !r.s2[IX_HOLD]) begin
					n.state = cpu_bus_pkg::ST_GRANTED;
				end else if (r.pend) begin
					n.pend = 1'b0;
					n.busy = 1'b1;
					n.state = r.arb ? cpu_bus_pkg::ST_ACCESS : cpu_bus_pkg::ST_REQ_BUS;
				end
			end
			cpu_bus_pkg::ST_GRANTED: begin
				if (r.s2[IX_HOLD]) n.state = cpu_bus_pkg::ST_IDLE;
			end
			cpu_bus_pkg::ST_REQ_BUS: begin
				if (!r.s2[IX_GRANT]) n.state = cpu_bus_pkg::ST_ACCESS;
			end
			cpu_bus_pkg::ST_ACCESS: begin
				if (!r.s2[IX_RELINQUISH_RETRY_REQUEST] && !r.lock) begin
					n.state = cpu_bus_pkg::ST_RELINQ;
				end else if (!r.s2[IX_RETRY]) begin
					n.state = cpu_bus_pkg::ST_RETRY;
				end else if (!r.s2[IX_FAULT]) begin
					n.fault = 1'b1;
					n.busy = 1'b0;
					n.lock = 1'b0;
					n.boot = 1'b0;
					n.processor_status_word.trace_mask_bit = 1'b0;
					n.processor_status_word.exception_type_field = r.boot ? `ET_RESET : `ET_NORMAL;
					n.processor_status_word.internal_state_code = r.boot ? `ISC_BOOT_FAULT : `ISC_BUS_FAULT;
					n.state = cpu_bus_pkg::ST_IDLE;
				end else if (!r.s2[IX_DATA_READY_STROBE]) begin
					if (r.boot) begin
						if (r.step == 2'h0) n.process_control_block = r.d2;
						if (r.step == 2'h1) n.processor_status_word = r.d2 & 32'h3FFF_FFFF;
						if (r.step == 2'h2) n.pc = r.d2;
						if (r.step == 2'h3) n.sp = r.d2;
						n.step = r.step + 2'h1;
						if (r.step == 2'h0) n.addr = r.d2;
						else if (r.step == 2'h1) n.addr = r.process_control_block + `PCB_PC_OFFSET;
						else if (r.step == 2'h2) n.addr = r.process_control_block + `PCB_SP_OFFSET;
						if (r.step == 2'h3) begin
							n.boot = 1'b0;
							n.busy = 1'b0;
							n.start = 1'b1;
							n.processor_status_word.trace_mask_bit = 1'b1;
							n.state = cpu_bus_pkg::ST_IDLE;
						end else begin
							// end this fetch so the strobe rises before the next one
							n.state = cpu_bus_pkg::ST_RETRY;
						end
					end else if (r.lock && !r.write) begin
						n.rdata = r.d2;
						n.equal = r.d2 == r.cmp;
						if (r.op == cpu_bus_pkg::OP_SWAP || r.d2 == r.cmp) begin
							n.state = cpu_bus_pkg::ST_LOCKED;
						end else begin
							n.lock = 1'b0;
							n.busy = 1'b0;
							n.state = cpu_bus_pkg::ST_IDLE;
						end
					end else begin
						if (!r.write) n.rdata = r.d2;
						n.lock = 1'b0;
						n.busy = 1'b0;
						n.state = cpu_bus_pkg::ST_IDLE;
					end
				end
			end
			cpu_bus_pkg::ST_LOCKED: begin
				n.write = 1'b1;
				// wait until the old data ready has gone away
				if (r.s2[IX_DATA_READY_STROBE]) n.state = cpu_bus_pkg::ST_ACCESS;
			end
			cpu_bus_pkg::ST_RETRY: begin
				if (r.s2[IX_RETRY] && r.s2[IX_DATA_READY_STROBE]) n.state = cpu_bus_pkg::ST_ACCESS;
			end
			cpu_bus_pkg::ST_RELINQ: begin
				if (r.s2[IX_RELINQUISH_RETRY_REQUEST] && r.s2[IX_RETRY]) begin
					n.state = r.arb ? cpu_bus_pkg::ST_ACCESS : cpu_bus_pkg::ST_REQ_BUS;
				end
			end
			default: n.state = cpu_bus_pkg::ST_RESET_HOLD;
		endcase
		// reset request overrides everything
		if (!r.s2[IX_RST]) begin
			n.state = cpu_bus_pkg::ST_RESET_HOLD;
			n.pend = 1'b0;
			n.busy = 1'b0;
			n.lock = 1'b0;
			n.boot = 1'b0;
			n.since = 7'h00;
			n.processor_status_word.exception_type_field = `ET_RESET;
			n.processor_status_word.register_save = 1'b0;
		end
	end

	// state register with clock enable
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			r <= '0;
		end else if (ce_i) begin
			r <= n;
		end
	end

	// pin drive by state
	always_comb begin
		addr_o = r.addr;
		data_o = r.dout;
		addr_oe_o = owns_bus;
		data_oe_o = (r.state == cpu_bus_pkg::ST_ACCESS) && r.write;
		transfer_size_outputs_o = owns_bus ? {1'b0, r.size} : 3'h0;
		size_oe_o = owns_bus || (r.arb && !floated && !in_reset);
		strobe_oe_o = r.arb ? !floated : owns_bus;
		mode_oe_o = strobe_oe_o;
		addr_strobe_n_o = r.state != cpu_bus_pkg::ST_ACCESS;
		data_strobe_n_o = r.state != cpu_bus_pkg::ST_ACCESS;
		read_not_write_o = !(owns_bus && r.write);
		virtual_address_indicator_o = in_reset ? 1'b0 : `VAD_PHYSICAL;
		access_mode_outputs_o = (in_reset || r.boot) ? `XMD_KERNEL : r.processor_status_word.current_level;
		bus_grant_ack_n_o = r.state != cpu_bus_pkg::ST_GRANTED;
		bus_hold_request_n_o = r.arb || in_reset ||
			!(owns_bus || r.state == cpu_bus_pkg::ST_REQ_BUS);
		reset_ack_n_o = !in_reset;
		relinquish_retry_ack_o = 1'b0;
		relinquish_retry_ack_oe_o = (r.state == cpu_bus_pkg::ST_RELINQ) && !in_reset;
		queue_status_outputs_o = 2'h3;
		instruction_start_n_o = !r.start;
		initial_context_o = r.processor_status_word.register_initial_context;
		save_registers_o = r.processor_status_word.register_save;
		avs_readdata_o = r.rdbus;
		avs_waitrequest_o = avs_read_i && !r.rd_ack;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	a_grant_float: assert property (!bus_grant_ack_n_o |-> !addr_oe_o && !data_oe_o && !strobe_oe_o && !mode_oe_o
		&& reset_ack_n_o && !relinquish_retry_ack_oe_o) else $error("granted bus not floated");
	a_reset_wins: assert property (ce_i && !r.s2[IX_RST] |=> !reset_ack_n_o && !r.busy)
		else $error("reset request not acknowledged");
	a_hold_count: assert property (ce_i && r.state == cpu_bus_pkg::ST_RESET_COUNT && r.cnt == HOLD_LAST
		&& r.s2[IX_RST] |=> reset_ack_n_o && r.boot && r.addr == `BOOT_VECTOR_ADDR)
		else $error("reset hold length wrong");
	a_hold_keep: assert property (r.state == cpu_bus_pkg::ST_RESET_COUNT && r.cnt < HOLD_LAST |-> !reset_ack_n_o)
		else $error("reset ack released early");
	a_rrack_reset: assert property (!reset_ack_n_o |-> !relinquish_retry_ack_oe_o)
		else $error("relinquish ack driven in reset");
	a_lock_no_grant: assert property (r.lock && r.busy |-> bus_grant_ack_n_o && !relinquish_retry_ack_oe_o)
		else $error("handover inside interlock");
	a_arb_idle_pins: assert property (r.arb && reset_ack_n_o && r.state == cpu_bus_pkg::ST_IDLE
		|-> strobe_oe_o && addr_strobe_n_o && size_oe_o && transfer_size_outputs_o == 3'h0)
		else $error("arbiter idle pins wrong");
	a_byte_copy: assert property (data_oe_o && r.size == cpu_bus_pkg::SZ_BYTE
		|-> data_o == {4{data_o[7:0]}}) else $error("byte not replicated");
	a_vad_phys: assert property (r.since >= `VAD_SETTLE_CYCLES |-> virtual_address_indicator_o == `VAD_PHYSICAL)
		else $error("address mode not physical");
	a_xmd_kernel: assert property (r.since >= `XMD_SETTLE_CYCLES && r.since < `VAD_SETTLE_CYCLES && r.boot
		|-> access_mode_outputs_o == `XMD_KERNEL) else $error("access mode not kernel");
	a_relinq_first: assert property (ce_i && r.state == cpu_bus_pkg::ST_ACCESS && !r.lock && !r.s2[IX_RELINQUISH_RETRY_REQUEST]
		&& r.s2[IX_RST] |=> relinquish_retry_ack_oe_o && !addr_oe_o) else $error("relinquish not honoured");
	a_fault_type: assert property (ce_i && r.state == cpu_bus_pkg::ST_ACCESS && r.s2[IX_RELINQUISH_RETRY_REQUEST] && r.s2[IX_RETRY]
		&& !r.s2[IX_FAULT] && !r.boot && r.s2[IX_RST] |=> r.fault && r.processor_status_word.exception_type_field == `ET_NORMAL
		&& !r.processor_status_word.trace_mask_bit) else $error("fault not taken");
endmodule : cpu_bus_reset_control
`default_nettype wire

//--- core/cpu_bus_defines.svh
// constants of the bus and reset control block
`ifndef CPU_BUS_DEFINES_SVH
`define CPU_BUS_DEFINES_SVH
`define RESET_HOLD_CYCLES 128
`define VAD_SETTLE_CYCLES 7'h42
`define XMD_SETTLE_CYCLES 7'h12
`define BOOT_VECTOR_ADDR 32'h0000_0080
`define PCB_PC_OFFSET 32'h0000_0004
`define PCB_SP_OFFSET 32'h0000_0008
`define REG_PSW 6'h00
`define REG_ADDR 6'h04
`define REG_WDATA 6'h08
`define REG_CMP 6'h0C
`define REG_CTRL 6'h10
`define REG_RDATA 6'h14
`define REG_PCB 6'h18
`define REG_PC 6'h1C
`define REG_SP 6'h20
`define PSW_RESET 32'h0000_0000
`define PSW_WR_MASK 32'h3FFF_FE80
`define ET_RESET 2'h0
`define ET_PROCESS 2'h1
`define ET_STACK 2'h2
`define ET_NORMAL 2'h3
`define ISC_BOOT_FAULT 4'h1
`define ISC_BUS_FAULT 4'h5
`define XMD_KERNEL 2'h0
`define VAD_PHYSICAL 1'b1
`endif

//--- core/cpu_bus_pkg.sv
// types of the bus and reset control block
package cpu_bus_pkg;
	typedef enum logic [3:0] {
		ST_RESET_HOLD, ST_RESET_COUNT, ST_IDLE, ST_GRANTED, ST_REQ_BUS,
		ST_ACCESS, ST_RETRY, ST_RELINQ, ST_LOCKED
	} state_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_THREE, SZ_WORD} size_t;
	typedef enum logic [1:0] {OP_PLAIN, OP_SWAP, OP_COND_SWAP, OP_RSVD} op_t;
	// status word layout, bit 31 first
	typedef struct packed {
		logic [1:0] unused;
		logic [3:0] flags;
		logic cache_flush_disable;
		logic quick_interrupt_enable;
		logic cache_disable;
		logic overflow_enable;
		logic [3:0] condition_codes;
		logic trace_enable_bit;
		logic [3:0] interrupt_priority;
		logic [1:0] current_level;
		logic [1:0] previous_level;
		logic register_save;
		logic register_initial_context;
		logic [3:0] internal_state_code;
		logic trace_mask_bit;
		logic [1:0] exception_type_field;
	} psw_t;
endpackage : cpu_bus_pkg

//--- core/write_lane_replicator.sv
// write data lane placement and byte replication
`timescale 1ns/1ps
`default_nettype none
module write_lane_replicator (
	input wire logic [1:0] offset_i, // address bits 1:0
	input wire cpu_bus_pkg::size_t size_i, // transfer size
	input wire logic [31:0] data_i, // right-aligned operand
	output logic [31:0] lanes_o // lanes, bits 31:24 for offset 0
);
	logic [7:0] b0, b1, b2;
	assign b0 = data_i[7:0];
	assign b1 = data_i[15:8];
	assign b2 = data_i[23:16];
	// undefined lanes are zero for offset-1 halfwords and three-byte writes; bytes and other halfwords copy the operand
	always_comb begin
		lanes_o = data_i;
		case (size_i)
			cpu_bus_pkg::SZ_BYTE: lanes_o = {4{b0}};
			cpu_bus_pkg::SZ_HALF: begin
				if (offset_i == 2'h1) lanes_o = {8'h00, b1, b0, 8'h00};
				else lanes_o = {2{b1, b0}};
			end
			cpu_bus_pkg::SZ_THREE: begin
				if (offset_i == 2'h0) lanes_o = {b2, b1, b0, 8'h00};
				else if (offset_i == 2'h1) lanes_o = {8'h00, b2, b1, b0};
				else lanes_o = 32'h0000_0000;
			end
			default: lanes_o = data_i;
		endcase
	end
endmodule : write_lane_replicator
`default_nettype wire

//--- verif/bus_memory_model.sv
// memory and bus arbiter standing at the far side of the bus pins
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model (
	input wire logic clk_i, // bench clock
	input wire logic [31:0] addr_i, // address pins
	input wire logic strobe_n_i, // address strobe
	input wire logic strobe_oe_i, // strobe driven
	input wire logic hold_n_i, // the block wants the bus
	input wire logic [1:0] delay_i, // answer delay in cycles
	output logic ready_n_o, // access done
	output logic [31:0] data_o, // read data
	output logic grant_n_o // bus granted
);
	int cnt = 0;
	initial begin
		ready_n_o = 1'b1;
		data_o = 32'h0;
		grant_n_o = 1'b1;
	end
	// memory contents: pointer word at 0x80, a pattern elsewhere
	function automatic logic [31:0] word(input logic [31:0] a);
		return (a == 32'h80) ? 32'h100 : {a[15:0] ^ 16'h5A3C, a[15:0]};
	endfunction : word
	// answer after the delay, hold ready and data until the strobe rises, scramble data when released
	always @(posedge clk_i) begin
		grant_n_o <= hold_n_i;
		if (!strobe_oe_i || strobe_n_i) begin
			cnt = 0;
			ready_n_o <= 1'b1;
			data_o <= ~data_o;
		end else if (cnt < delay_i) begin
			cnt++;
		end else begin
			ready_n_o <= 1'b0;
			data_o <= word(addr_i);
		end
	end
endmodule : bus_memory_model
`default_nettype wire

//--- verif/cpu_bus_reset_control_tb.sv
// self-checking bench of the bus and reset control block
`include "cpu_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_reset_control_tb;
	localparam int HOLD = 8;
	logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, data_i, data_o, addr_o;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic reset_request_n_i = 1'b1, arbiter_select_strap_i = 1'b0, bus_hold_request_n_i = 1'b1;
	logic relinquish_retry_request_n_i = 1'b1, retry_n_i = 1'b1, fault_n_i = 1'b1;
	logic avs_waitrequest_o, bus_grant_n_i, data_ready_strobe_n_i, data_oe_o, addr_oe_o, size_oe_o;
	logic addr_strobe_n_o, data_strobe_n_o, read_not_write_o, strobe_oe_o, virtual_address_indicator_o;
	logic mode_oe_o, bus_grant_ack_n_o, bus_hold_request_n_o, reset_ack_n_o, relinquish_retry_ack_o;
	logic relinquish_retry_ack_oe_o, instruction_start_n_o, initial_context_o, save_registers_o;
	logic [2:0] transfer_size_outputs_o;
	logic [1:0] access_mode_outputs_o, queue_status_outputs_o, o, s, slow = 2'd1;
	logic as_q = 1'b0, wr_seen = 1'b0, early_grant = 1'b0;
	logic [31:0] rnd = 32'h6742AD0D, last_wr, q, p, cq, d;
	logic [63:0] ex;
	int checks = 0, err_total = 0, n_acc = 0, base, cnt;

	cpu_bus_reset_control #(.HOLD_CYCLES(HOLD)) dut (.clk_i, .reset_i, .ce_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .reset_request_n_i,
		.arbiter_select_strap_i, .bus_hold_request_n_i, .bus_grant_n_i, .relinquish_retry_request_n_i, .retry_n_i,
		.fault_n_i, .data_ready_strobe_n_i, .data_i, .data_o, .data_oe_o, .addr_o, .addr_oe_o, .transfer_size_outputs_o,
		.size_oe_o, .addr_strobe_n_o, .data_strobe_n_o, .read_not_write_o, .strobe_oe_o, .virtual_address_indicator_o,
		.access_mode_outputs_o, .mode_oe_o, .bus_grant_ack_n_o, .bus_hold_request_n_o, .reset_ack_n_o,
		.relinquish_retry_ack_o, .relinquish_retry_ack_oe_o, .queue_status_outputs_o, .instruction_start_n_o,
		.initial_context_o, .save_registers_o);
	bus_memory_model mem (.clk_i(clk_i), .addr_i(addr_o), .strobe_n_i(addr_strobe_n_o), .strobe_oe_i(strobe_oe_o),
		.hold_n_i(bus_hold_request_n_o), .delay_i(slow), .ready_n_o(data_ready_strobe_n_i), .data_o(data_i),
		.grant_n_o(bus_grant_n_i));

	// clock
	initial forever #5 clk_i = ~clk_i;
	// count access starts, catch write lanes, note a grant before the write
	always @(posedge clk_i) begin
		as_q <= strobe_oe_o & ~addr_strobe_n_o;
		if (strobe_oe_o & ~addr_strobe_n_o & ~as_q) n_acc++;
		if (data_oe_o === 1'b1) begin
			last_wr = data_o;
			wr_seen = 1'b1;
		end
		if (bus_grant_ack_n_o === 1'b0 && !wr_seen) early_grant = 1'b1;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
	endfunction : lfsr
	// expected lanes in the upper half, mask of defined lanes in the lower half
	function automatic logic [63:0] lanes(input logic [1:0] a, input logic [1:0] z, input logic [31:0] v);
		case (z)
			2'd0: return {{4{v[7:0]}}, 32'hFFFFFFFF};
			2'd1: return a == 2'd1 ? {8'h00, v[15:0], 8'h00, 32'h00FFFF00} : {{2{v[15:0]}}, 32'hFFFFFFFF};
			2'd2: return a == 2'd0 ? {v[23:0], 8'h00, 32'hFFFFFF00} : {8'h00, v[23:0], 32'h00FFFFFF};
			default: return {v, 32'hFFFFFFFF};
		endcase
	endfunction : lanes
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one register bus cycle, held until waitrequest is low at a rising edge
	task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] v, output logic [31:0] r);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= v;
		avs_read_i <= rd;
		avs_write_i <= ~rd;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus
	task automatic until_sig(input int w, input logic v);
		int n;
		n = 0;
		while ((w == 0 ? bus_grant_ack_n_o : w == 1 ? reset_ack_n_o : relinquish_retry_ack_oe_o) !== v && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		cnt = n;
	endtask : until_sig
	// start an access; pins {hold, relinquish, retry, fault} go low once the strobe is seen
	task automatic go(input logic [31:0] a, input logic [31:0] w, input logic [4:0] ctl, input logic [3:0] pins);
		int n;
		bus(1'b0, 6'h04, a, q);
		bus(1'b0, 6'h08, w, q);
		bus(1'b0, 6'h10, {27'h0, ctl}, q);
		base = n_acc;
		if (pins != 4'h0) begin
			n = 0;
			while (!(strobe_oe_o === 1'b1 && addr_strobe_n_o === 1'b0) && n < 50) begin
				@(posedge clk_i);
				n++;
			end
			{bus_hold_request_n_i, relinquish_retry_request_n_i, retry_n_i, fault_n_i} <= ~pins;
			@(posedge clk_i);
			if (pins[2]) begin
				until_sig(2, 1'b1);
				chk(addr_oe_o, 1'b0);
			end
			{relinquish_retry_request_n_i, retry_n_i, fault_n_i} <= 3'b111;
		end
		n = 0;
		do begin
			bus(1'b1, 6'h10, 32'h0, cq);
			n++;
		end while (cq[8] !== 1'b0 && n < 100);
	endtask : go
	// system reset request, acknowledge, hold count and boot fetches
	task automatic boot(input logic strap);
		arbiter_select_strap_i <= strap;
		reset_request_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({reset_ack_n_o, save_registers_o, relinquish_retry_ack_oe_o}, 3'b000);
		reset_request_n_i <= 1'b1;
		until_sig(1, 1'b1);
		chk(cnt >= HOLD && cnt <= HOLD + 6, 1'b1);
		chk({strobe_oe_o, queue_status_outputs_o, relinquish_retry_ack_oe_o}, {~strap, 3'b110});
		repeat (18) @(posedge clk_i);
		chk(access_mode_outputs_o, `XMD_KERNEL);
		repeat (48) @(posedge clk_i);
		chk(virtual_address_indicator_o, `VAD_PHYSICAL);
		repeat (100) @(posedge clk_i);
		for (int j = 0; j < 3; j++) begin
			bus(1'b1, 6'(24 + 4 * j), 32'h0, q);
			chk(q, j == 0 ? 32'h100 : mem.word(32'h100 + 32'(4 * j)));
		end
	endtask : boot
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	// watchdog
	initial begin
		#400000;
		err_total++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		boot(1'b0);
		bus(1'b1, 6'h3C, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, 6'h00, 32'h0, p);
		bus(1'b0, 6'h00, 32'hFFFFFFFF, q);
		bus(1'b1, 6'h00, 32'h0, q);
		chk(q & 32'hC000017F, p & 32'hC000017F);
		chk(q & `PSW_WR_MASK, `PSW_WR_MASK);
		chk(initial_context_o, 1'b1);
		// random writes of every legal size, each at a legal offset
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(lfsr(lfsr(rnd)));
			d = lfsr(lfsr(rnd));
			{slow, s, o} = rnd[5:0];
			if (s == 2'd2) o[1] = 1'b0;
			if (s == 2'd1 && o == 2'd3) o = 2'd2;
			if (s == 2'd3) o = 2'd0;
			ex = lanes(o, s, d);
			go({rnd[31:2], o}, d, {3'b001, s}, 4'h0);
			chk(last_wr & ex[31:0], ex[63:32] & ex[31:0]);
		end
		// retry alone, all three exceptions together, a lone fault
		slow <= 2'd3;
		go(32'h200, 32'h0, 5'h03, 4'h2);
		chk({n_acc - base, cq[9]}, {32'd2, 1'b0});
		go(32'h204, 32'h0, 5'h03, 4'h7);
		chk({n_acc - base, cq[9]}, {32'd2, 1'b0});
		go(32'h208, 32'h0, 5'h03, 4'h1);
		chk(cq[9], 1'b1);
		bus(1'b1, 6'h00, 32'h0, q);
		chk(q[6:2], {`ISC_BUS_FAULT, 1'b0});
		// conditional swap: equal operands write, unequal do not
		for (int k = 0; k < 2; k++) begin
			bus(1'b0, 6'h0C, mem.word(32'h300) ^ 32'(k), q);
			wr_seen = 1'b0;
			go(32'h300, 32'hC0DE0000, 5'h13, 4'h0);
			chk(wr_seen, k == 0);
		end
		bus(1'b1, 6'h14, 32'h0, q);
		chk(q, mem.word(32'h300));
		// swap under a hold request: grant only after the write, then handover and return
		early_grant = 1'b0;
		wr_seen = 1'b0;
		go(32'h304, 32'h1234, 5'h0B, 4'h8);
		chk({wr_seen, early_grant, last_wr}, {2'b10, 32'h1234});
		until_sig(0, 1'b0);
		chk({addr_oe_o, data_oe_o, size_oe_o, strobe_oe_o, mode_oe_o, reset_ack_n_o}, 6'b000001);
		bus_hold_request_n_i <= 1'b1;
		until_sig(0, 1'b1);
		repeat (2) @(posedge clk_i);
		chk(strobe_oe_o, 1'b1);
		// not arbiter: the block asks the partner for the bus
		boot(1'b1);
		go(32'h400, 32'h0, 5'h03, 4'h0);
		chk({n_acc - base, cq[9]}, {32'd1, 1'b0});
		summarize();
	end
endmodule : cpu_bus_reset_control_tb
`default_nettype wire
